// ### verilog/foc_modulator_gate_regs.sv
// Modulator control, gate pass-through, hall angle table and waveform store registers
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "foc_regs_cfg.svh"

// What this block does
// - With transition set, hold bit keeps vector seven, else falls
// - Transition bit allows zero or seven null
// - Mode table: off, one shot, symmetric
// - Four-bit prescaler in bits eleven to eight
// - Eight-bit clock divider in low byte
// - Pulse period is (div+1) times (presc+1)
// - Dead-time byte, resets to all ones
// - Dead-time passed unchanged to gate unit
// - Gate switch count readable, report only
// - Hall entries eighteen-bit signed, reset zero
// - Sixteen hall entries read by sensor
// - Waveform store 1024 by 18, dual port
// - Four tables of 256 consecutive entries
// - Two-bit table selector picks generator table
module foc_modulator_gate_regs
   import foc_regs_pkg::*;
(
   input  wire logic                 MCLK_IN,
   input  wire logic                 RST_IN,
   input  wire logic [11:0]          ADDR_IN,
   input  wire logic [31:0]          WR_DATA_IN,
   input  wire logic                 WR_IN,
   input  wire logic                 RD_IN,
   output logic      [31:0]          RD_DATA_OUT,
   input  wire logic [2:0]           VEC_REQ_IN,
   output logic                      PFM_TICK_OUT,
   output logic      [1:0]           NULL_MODE_OUT,
   output logic      [2:0]           NULL_VEC_OUT,
   output logic      [7:0]           DEAD_TIME_OUT,
   input  wire logic [31:0]          SWITCH_COUNT_IN,
   input  wire logic [3:0]           HALL_SEL_IN,
   output logic      [`HALL_W-1:0]   HALL_ANGLE_OUT,
   input  wire logic [7:0]           GEN_ADDR_IN,
   output logic      [`WAVE_W-1:0]   GEN_DATA_OUT
);
   // ==========================================
   // Host request decode
   host_req_t          req;
   pfm_ctrl_t          pfm_ctrl;
   null_mode_t         null_mode;
   logic [7:0]         dead_time;
   logic [1:0]         table_sel;
   logic [`HALL_W-1:0] hall [`HALL_ENTRIES];
   logic               hit_hall;
   logic               hit_wave;
   logic [`WAVE_W-1:0] wave_rdata;
   logic [7:0]         div_cnt;
   logic [3:0]         pre_cnt;
   logic               div_wrap;
   logic               tick;
   logic [2:0]         next_vec;
   logic [1:0]         prev_ones;

   assign req      = '{addr: ADDR_IN, wdata: WR_DATA_IN, wr: WR_IN, rd: RD_IN};
   assign hit_hall = (req.addr[11:4] == `HALL_PAGE);
   assign hit_wave = (req.addr[11:10] == `WAVE_PAGE);

   // ==========================================
   // Control registers
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         pfm_ctrl <= `PFM_CTRL_RST;
      end else if (req.wr && req.addr == `ADDR_PFM_CTRL) begin
         pfm_ctrl <= req.wdata[`PFM_CTRL_W-1:0];
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         dead_time <= `DEAD_TIME_RST;
      end else if (req.wr && req.addr == `ADDR_DEAD_TIME) begin
         dead_time <= req.wdata[7:0];
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         table_sel <= `PWM_TABLE_RST;
      end else if (req.wr && req.addr == `ADDR_PWM_CTRL) begin
         table_sel <= req.wdata[`PWM_TABLE_MSB:`PWM_TABLE_LSB];
      end
   end

   // ==========================================
   // Hall angle entries
   genvar gi;
   generate
      for (gi = 0; gi < `HALL_ENTRIES; gi++) begin : g_hall
         always_ff @(posedge MCLK_IN) begin
            if (RST_IN) begin
               hall[gi] <= `HALL_RST;
            end else if (req.wr && hit_hall && req.addr[3:0] == 4'(gi)) begin
               hall[gi] <= req.wdata[`HALL_W-1:0];
            end
         end
      end
   endgenerate

   // Sensor side lookup, one cycle late like every other output
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         HALL_ANGLE_OUT <= '0;
      end else begin
         HALL_ANGLE_OUT <= hall[HALL_SEL_IN];
      end
   end

   // ==========================================
   // Waveform store
   waveform_dpr u_wave (
      .clk_in         (MCLK_IN),
      .rst_in         (RST_IN),
      .host_we_in     (req.wr && hit_wave),
      .host_addr_in   (req.addr[`WAVE_AW-1:0]),
      .host_wdata_in  (req.wdata[`WAVE_W-1:0]),
      .host_rdata_out (wave_rdata),
      .gen_addr_in    ({table_sel, GEN_ADDR_IN}),
      .gen_data_out   (GEN_DATA_OUT)
   );

   // ==========================================
   // Read path: data stands the cycle after the strobe only
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         RD_DATA_OUT <= '0;
      end else if (!req.rd) begin
         RD_DATA_OUT <= '0;
      end else if (hit_hall) begin
         // Sign stays in bit 17; upper bits reserved and read as zero
         RD_DATA_OUT <= {14'h0000, hall[req.addr[3:0]]};
      end else if (hit_wave) begin
         RD_DATA_OUT <= {14'h0000, wave_rdata};
      end else begin
         unique case (req.addr)
            `ADDR_PFM_CTRL:   RD_DATA_OUT <= {18'h00000, pfm_ctrl};
            `ADDR_DEAD_TIME:  RD_DATA_OUT <= {24'h000000, dead_time};
            `ADDR_SWITCH_CNT: RD_DATA_OUT <= SWITCH_COUNT_IN;
            `ADDR_PWM_CTRL:   RD_DATA_OUT <= {30'h00000000, table_sel};
            default:          RD_DATA_OUT <= '0;
         endcase
      end
   end

   // ==========================================
   // Gate unit pass-through
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         DEAD_TIME_OUT <= `DEAD_TIME_RST;
      end else begin
         DEAD_TIME_OUT <= dead_time;
      end
   end

   // ==========================================
   // Pulse timing divider
   assign div_wrap = (div_cnt == pfm_ctrl.div);
   assign tick     = div_wrap && (pre_cnt == pfm_ctrl.presc);

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         div_cnt <= '0;
      end else if (div_wrap) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   // Fields shrunk under a running count wrap at the next full cycle
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         pre_cnt <= '0;
      end else if (tick) begin
         pre_cnt <= '0;
      end else if (div_wrap) begin
         pre_cnt <= pre_cnt + 4'h1;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         PFM_TICK_OUT <= 1'b0;
      end else begin
         PFM_TICK_OUT <= tick;
      end
   end

   // ==========================================
   // Null vector selection
   always_comb begin
      if (!pfm_ctrl.trans) begin
         null_mode = NULL_V7_OFF;
      end else if (pfm_ctrl.hold) begin
         null_mode = NULL_SYM;
      end else begin
         null_mode = NULL_V7_ONCE;
      end
   end

   // Previous vector with two or more high legs is nearer to seven
   assign prev_ones = 2'(NULL_VEC_OUT[0]) + 2'(NULL_VEC_OUT[1]) + 2'(NULL_VEC_OUT[2]);

   always_comb begin
      next_vec = VEC_REQ_IN;
      if (VEC_REQ_IN == `VEC_SEVEN || VEC_REQ_IN == `VEC_ZERO) begin
         unique case (null_mode)
            NULL_V7_OFF: begin
               next_vec = `VEC_ZERO;
            end
            NULL_V7_ONCE: begin
               if (VEC_REQ_IN == `VEC_SEVEN) begin
                  next_vec = (NULL_VEC_OUT == `VEC_SEVEN) ? `VEC_ZERO : `VEC_SEVEN;
               end else begin
                  next_vec = (prev_ones >= 2'd2) ? `VEC_SEVEN : `VEC_ZERO;
               end
            end
            NULL_SYM: begin
               if (VEC_REQ_IN == `VEC_SEVEN) begin
                  next_vec = `VEC_SEVEN;
               end else begin
                  next_vec = (prev_ones >= 2'd2) ? `VEC_SEVEN : `VEC_ZERO;
               end
            end
            default: begin
               next_vec = `VEC_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         NULL_VEC_OUT <= `VEC_ZERO;
      end else if (tick) begin
         NULL_VEC_OUT <= next_vec;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         NULL_MODE_OUT <= NULL_V7_OFF;
      end else begin
         NULL_MODE_OUT <= null_mode;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);

   logic [11:0] gap;
   logic        settled;
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN || tick) begin
         gap <= '0;
      end else begin
         gap <= gap + 12'h001;
      end
   end
   // Period is only checked for a whole period without a control write
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN || (req.wr && req.addr == `ADDR_PFM_CTRL)) begin
         settled <= 1'b0;
      end else if (tick) begin
         settled <= 1'b1;
      end
   end

   pulse_period_a: assert property (
      tick && settled |-> 16'(gap) == 16'((16'(pfm_ctrl.div) + 16'h1) *
                                          (16'(pfm_ctrl.presc) + 16'h1) - 16'h1))
      else $error("pulse period differs from divider times prescaler");

   ctrl_fields_a: assert property (
      req.wr && req.addr == `ADDR_PFM_CTRL |=>
         pfm_ctrl.presc == $past(WR_DATA_IN[11:8]) && pfm_ctrl.div == $past(WR_DATA_IN[7:0]))
      else $error("control fields not stored");

   dead_pass_a: assert property (
      WR_IN && ADDR_IN == `ADDR_DEAD_TIME ##1 !(WR_IN && ADDR_IN == `ADDR_DEAD_TIME) |=>
         DEAD_TIME_OUT == $past(WR_DATA_IN[7:0], 2))
      else $error("dead time not passed unchanged");

   count_read_a: assert property (
      RD_IN && ADDR_IN == `ADDR_SWITCH_CNT |=> RD_DATA_OUT == $past(SWITCH_COUNT_IN))
      else $error("switch count readback wrong");

   v7_off_a: assert property (
      tick && !pfm_ctrl.trans && (VEC_REQ_IN == `VEC_SEVEN || VEC_REQ_IN == `VEC_ZERO) |=>
         NULL_VEC_OUT == `VEC_ZERO && PFM_TICK_OUT)
      else $error("vector seven used while disabled");

   sym_hold_a: assert property (
      tick && null_mode == NULL_SYM && VEC_REQ_IN == `VEC_SEVEN |=> NULL_VEC_OUT == `VEC_SEVEN)
      else $error("vector seven not held in symmetric mode");

   one_shot_a: assert property (
      tick && null_mode == NULL_V7_ONCE && VEC_REQ_IN == `VEC_SEVEN &&
         NULL_VEC_OUT == `VEC_SEVEN |=> NULL_VEC_OUT == `VEC_ZERO)
      else $error("vector seven repeated in one shot mode");

   hall_path_a: assert property (
      WR_IN && hit_hall ##1 (HALL_SEL_IN == $past(ADDR_IN[3:0]) &&
         !(WR_IN && hit_hall)) |=> HALL_ANGLE_OUT == $past(WR_DATA_IN[17:0], 2))
      else $error("hall entry not seen by sensor side");

   wave_write_a: assert property (
      WR_IN && hit_wave ##1 ({table_sel, GEN_ADDR_IN} == $past(ADDR_IN[9:0]) &&
         !(WR_IN && hit_wave)) |=> GEN_DATA_OUT == $past(WR_DATA_IN[17:0], 2))
      else $error("generator missed host write");

   trans_hold_a: assert property (
      req.wr && req.addr == `ADDR_PFM_CTRL |=>
         pfm_ctrl.trans == $past(WR_DATA_IN[`PFM_TRANS_BIT]) &&
         pfm_ctrl.hold == $past(WR_DATA_IN[`PFM_HOLD_BIT]))
      else $error("null vector mode bits not stored");

   table_sel_a: assert property (
      req.wr && req.addr == `ADDR_PWM_CTRL |=> table_sel == $past(WR_DATA_IN[1:0]))
      else $error("table selector not stored");

   // Mode follows the fields one cycle late, like every other output
   null_mode_a: assert property (
      1'b1 |=> NULL_MODE_OUT == ($past(pfm_ctrl.trans) ?
         ($past(pfm_ctrl.hold) ? 2'h2 : 2'h1) : 2'h0))
      else $error("null mode output does not follow the fields");

   // Upper bits read zero even when the host wrote ones there
   hall_upper_a: assert property (
      RD_IN && hit_hall |=> RD_DATA_OUT[31:18] == 14'h0000)
      else $error("hall readback upper bits not zero");

   tick_seen_c:  cover property (tick ##1 PFM_TICK_OUT);
   sym_seven_c:  cover property (tick && null_mode == NULL_SYM ##1 NULL_VEC_OUT == `VEC_SEVEN);
   wave_rd_c:    cover property (RD_IN && hit_wave ##1 RD_DATA_OUT != '0);
   table_last_c: cover property (table_sel == 2'h3 ##1 GEN_DATA_OUT != '0);
   once_seven_c: cover property (tick && null_mode == NULL_V7_ONCE ##1 NULL_VEC_OUT == `VEC_SEVEN);
endmodule
`default_nettype wire

// ### verilog/foc_regs_cfg.svh
// Register offsets, field positions, reset values and sizes for the modulator/gate bank
`ifndef FOC_REGS_CFG_SVH
`define FOC_REGS_CFG_SVH
// ==========================================
// Word addresses on the register port
`define ADDR_PFM_CTRL    12'h000
`define ADDR_DEAD_TIME   12'h001
`define ADDR_SWITCH_CNT  12'h002
`define ADDR_PWM_CTRL    12'h003
`define HALL_PAGE        8'h01
`define WAVE_PAGE        2'h1
// ==========================================
// Field positions
`define PFM_HOLD_BIT     13
`define PFM_TRANS_BIT    12
`define PFM_PRESC_MSB    11
`define PFM_PRESC_LSB    8
`define PFM_DIV_MSB      7
`define PFM_DIV_LSB      0
`define PFM_CTRL_W       14
`define PWM_TABLE_MSB    1
`define PWM_TABLE_LSB    0
// ==========================================
// Reset values
`define PFM_CTRL_RST     14'h0000
`define DEAD_TIME_RST    8'hff
`define HALL_RST         18'h00000
`define PWM_TABLE_RST    2'h0
// ==========================================
// Sizes and vector codes
`define HALL_ENTRIES     16
`define HALL_W           18
`define WAVE_DEPTH       1024
`define WAVE_AW          10
`define WAVE_W           18
`define VEC_ZERO         3'h0
`define VEC_SEVEN        3'h7
`endif

// ### verilog/foc_regs_pkg.sv
// Types shared by the modulator/gate register bank
`default_nettype none
package foc_regs_pkg;
   typedef struct packed {
      logic       hold;
      logic       trans;
      logic [3:0] presc;
      logic [7:0] div;
   } pfm_ctrl_t;

   typedef enum logic [1:0] {
      NULL_V7_OFF  = 2'b00,
      NULL_V7_ONCE = 2'b01,
      NULL_SYM     = 2'b10
   } null_mode_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } host_req_t;
endpackage
`default_nettype wire

// ### verilog/waveform_dpr.sv
// Dual-port waveform store: host read/write, generator read-only
`timescale 1ns/1ps
`default_nettype none
`include "foc_regs_cfg.svh"
module waveform_dpr (
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  host_we_in,
   input  wire logic [`WAVE_AW-1:0]   host_addr_in,
   input  wire logic [`WAVE_W-1:0]    host_wdata_in,
   output logic      [`WAVE_W-1:0]    host_rdata_out,
   input  wire logic [`WAVE_AW-1:0]   gen_addr_in,
   output logic      [`WAVE_W-1:0]    gen_data_out
);
   // ==========================================
   // Storage
   logic [`WAVE_W-1:0] mem [`WAVE_DEPTH];

   // Single-cycle write; generator sees it on its next read
   always_ff @(posedge clk_in) begin
      if (host_we_in) begin
         mem[host_addr_in] <= host_wdata_in;
      end
   end

   // Async host read keeps the register port at one cycle of latency
   assign host_rdata_out = mem[host_addr_in];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         gen_data_out <= '0;
      end else begin
         gen_data_out <= mem[gen_addr_in];
      end
   end
endmodule
`default_nettype wire

// ### dv/foc_far_side_model.sv
// Far-side model: gate unit switch counter and modulator vector request
`timescale 1ns/1ps
`default_nettype none
module foc_far_side_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        switch_in,
   input  wire logic [2:0]  vec_sel_in,
   output logic      [31:0] switch_count_out,
   output logic      [2:0]  vec_req_out
);
   // ==========================================
   // Gate unit switch counter
   // Starts near the top so a readback crosses the 32-bit wrap
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         switch_count_out <= 32'hfffffff0;
      end else if (switch_in) begin
         switch_count_out <= switch_count_out + 32'h1;
      end
   end
   // ==========================================
   // Modulator vector request, same clock
   always_comb vec_req_out = vec_sel_in;
endmodule
`default_nettype wire

// ### dv/foc_modulator_gate_regs_tb_top.sv
// Self-checking testbench for the modulator/gate register bank
`timescale 1ns/1ps
`default_nettype none
module foc_modulator_gate_regs_tb_top;
   logic        clk, rst, wr, rd, sw, tick, rd_d;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, swc;
   logic [2:0]  vsel, vreq, nvec, pv;
   logic [1:0]  nmode;
   logic [7:0]  dead, gaddr;
   logic [3:0]  hsel;
   logic [17:0] hang, gdata;
   logic [31:0] expq[$];
   logic [17:0] hv[16];
   logic [17:0] wv[4];
   int          fails, checks_done, cyc, d, p, r, t0;

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   foc_modulator_gate_regs uut (.MCLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
      .WR_DATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata),
      .VEC_REQ_IN(vreq), .PFM_TICK_OUT(tick), .NULL_MODE_OUT(nmode),
      .NULL_VEC_OUT(nvec), .DEAD_TIME_OUT(dead), .SWITCH_COUNT_IN(swc),
      .HALL_SEL_IN(hsel), .HALL_ANGLE_OUT(hang), .GEN_ADDR_IN(gaddr),
      .GEN_DATA_OUT(gdata));
   foc_far_side_model far (.clk_in(clk), .rst_in(rst), .switch_in(sw),
      .vec_sel_in(vsel), .switch_count_out(swc), .vec_req_out(vreq));

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [11:0] a, input logic [31:0] v);
      wr <= 1'b1;
      rd <= 1'b0;
      addr <= a;
      wdata <= v;
      @(posedge clk);
   endtask
   // Note goes on the queue; the watcher compares one cycle later
   task automatic rreg(input logic [11:0] a, input logic [31:0] e);
      expq.push_back(e);
      rd <= 1'b1;
      wr <= 1'b0;
      addr <= a;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (tick !== 1'b1 && n < 4200);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ==========================================
   // Read watcher and hang guard
   always @(posedge clk) begin
      rd_d <= rd;
      cyc <= cyc + 1;
      if (rd_d === 1'b1) begin
         chk(rdata, expq.pop_front());
      end
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 12'h000;
      wdata = 32'h0;
      sw = 1'b0;
      vsel = 3'h0;
      hsel = 4'h0;
      gaddr = 8'h00;
      void'($urandom(98));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      idle(1);
      chk(dead, 32'hff);
      rreg(12'h000, 32'h0);
      rreg(12'h001, 32'hff);
      rreg(12'h003, 32'h0);
      rreg(12'h01f, 32'h0);
      rreg(12'h005, 32'h0);
      idle(2);
      $display("reset values done");
      // Reserved bits written as ones must read back zero
      for (int m = 0; m < 4; m++) begin
         d = $urandom % 256;
         p = $urandom % 16;
         wreg(12'h000, {18'h3ffff, m[0], m[1], p[3:0], d[7:0]});
         rreg(12'h000, {18'h0, m[0], m[1], p[3:0], d[7:0]});
         idle(3);
         chk(nmode, m[1] ? (m[0] ? 2 : 1) : 0);
      end
      $display("control fields done");
      for (int k = 0; k < 3; k++) begin
         d = $urandom % 4;
         p = $urandom % 3;
         wreg(12'h000, {20'h0, p[3:0], d[7:0]});
         idle(1);
         repeat (2) wait_tick(t0);
         wait_tick(t0);
         chk(t0, (d + 1) * (p + 1));
      end
      $display("pulse period done");
      vsel <= 3'h7;
      // Counters may run past shrunk fields once before ticking every cycle
      wreg(12'h000, 32'h3000);
      idle(1);
      repeat (2) wait_tick(t0);
      idle(2);
      chk(nvec, 3'h7);
      wreg(12'h000, 32'h0);
      idle(4);
      chk(nvec, 3'h0);
      wreg(12'h000, 32'h1000);
      idle(3);
      pv = nvec;
      idle(1);
      chk(nvec ^ pv, 3'h7);
      vsel <= 3'h3;
      idle(4);
      chk(nvec, 3'h3);
      vsel <= 3'h0;
      idle(4);
      chk(nvec, 3'h7);
      $display("null vector done");
      for (int k = 0; k < 3; k++) begin
         d = $urandom % 256;
         wreg(12'h001, {24'hffffff, d[7:0]});
         rreg(12'h001, {24'h0, d[7:0]});
         idle(2);
         chk(dead, d[7:0]);
      end
      sw <= 1'b1;
      repeat (20) @(posedge clk);
      sw <= 1'b0;
      rreg(12'h002, 32'h4);
      idle(2);
      $display("gate values done");
      hsel <= 4'hf;
      for (int i = 0; i < 16; i++) begin
         hv[i] = 18'($urandom);
         wreg(12'(i + 16), {14'h3fff, hv[i]});
      end
      for (int i = 0; i < 16; i++) begin
         rreg(12'(i + 16), {14'h0, hv[i]});
      end
      for (int i = 0; i < 16; i++) begin
         hsel <= i[3:0];
         idle(2);
         chk(hang, hv[i]);
      end
      $display("hall table done");
      r = $urandom % 256;
      for (int t = 0; t < 4; t++) begin
         wv[t] = 18'($urandom);
         wreg(12'(1024 + t * 256 + r), {14'h0, wv[t]});
      end
      rreg(12'(1536 + r), {14'h0, wv[2]});
      gaddr <= r[7:0];
      for (int t = 0; t < 4; t++) begin
         wreg(12'h003, t);
         idle(3);
         chk(gdata, wv[t]);
      end
      rreg(12'h003, 32'h3);
      // Generator address already set, so the write must show next cycle
      wv[0] = ~wv[3];
      wreg(12'(1792 + r), {14'h0, wv[0]});
      idle(2);
      chk(gdata, wv[0]);
      $display("waveform store done");
      idle(3);
      final_report();
   end
endmodule
`default_nettype wire
